// ==== rtl/accu_xreg_exec.sv ====
// executor for x register calculation, accu transfers and flag clearing
`timescale 1ns/1ps
`include "xcalc_defs.svh"
// Summary of operation
// (RULE1) opcode 33 runs a calculation picked by type, accu first, x second.
// (RULE2) types 0..4 add, subtract, multiply, divide and modulo accu by x.
// (RULE3) types 5, 6, 7 give bitwise and, or, xor of accu with x.
// (RULE4) type 8 inverts the x register bitwise.
// (RULE5) type 9 copies accu into x and leaves accu alone.
// (RULE6) type 10 swaps accu and x in one step.
// (RULE7) arithmetic and logic results of types 0..7 land in the accumulator.
// (RULE8) opcode 34 writes accu to the axis parameter type for motor bank.
// (RULE9) opcode 35 writes accu to global parameter type in bank 0, 2 or 3.
// (RULE10) opcode 36 clears error flags chosen by type.
// (RULE11) clear type 0 clears all error flags at once.
// (RULE12) clear type 1 clears timeout only, type 2 external alarm only.
// (RULE13) clear type 3 clears deviation only, type 4 position error only.
// (RULE14) clear type 5 clears the shutdown flag only.
// (RULE15) each command answers: status 100 if valid, 4 for bad type or bank, 2 for bad opcode; value field meaningless.
// (RULE16) divide or modulo by zero keeps the accu and still completes.
// (RULE17) the issuer loads the accu before asking for a transfer.
module accu_xreg_exec (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_opcode,
    input  wire logic [7:0]  cmd_type,
    input  wire logic [7:0]  cmd_bank,
    input  wire logic [31:0] cmd_value,
    output logic             reply_valid,
    output logic [7:0]       reply_status,
    output logic [31:0]      reply_value,
    input  wire logic        accu_load,
    input  wire logic [31:0] accu_load_data,
    output logic [31:0]      accu,
    output logic [31:0]      xreg,
    output logic             axis_wr,
    output logic [7:0]       axis_param_num,
    output logic [7:0]       axis_motor,
    output logic [31:0]      axis_wdata,
    output logic             global_wr,
    output logic [7:0]       global_param_num,
    output logic [7:0]       global_bank,
    output logic [31:0]      global_wdata,
    input  wire logic [4:0]  error_set,
    output logic [4:0]       error_flags
);
    import xcalc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // command decode
    xcalc_pkg::exec_state_t state_r;
    xcalc_pkg::exec_state_t state_nxt;
    logic [31:0] accu_r;
    logic [31:0] xreg_r;
    logic [4:0]  flags_r;
    logic [7:0]  op_r;
    logic        rep_v_r;
    logic [7:0]  rep_s_r;
    logic        ax_wr_r;
    logic        gl_wr_r;
    logic [7:0]  wp_num_r;
    logic [7:0]  wp_sel_r;
    logic [31:0] wdata_r;
    logic        div_start;
    logic        div_done;
    logic [31:0] div_q;
    logic [31:0] div_r;

    wire       take     = cmd_valid && cmd_ready;
    wire       is_accu_calculate  = cmd_opcode == `OPC_XREG_ACCU_CALCULATE;  // see RULE1
    wire       is_axis  = cmd_opcode == `OPC_ACCU_AXIS;
    wire       is_glob  = cmd_opcode == `OPC_ACCU_GLOBAL;
    wire       is_clr   = cmd_opcode == `OPC_CLEAR_FLAGS;
    wire       bank_ok  = cmd_bank == `BANK_ALLOWED_0 ||
                          cmd_bank == `BANK_ALLOWED_2 ||
                          cmd_bank == `BANK_ALLOWED_3;  // see RULE9
    wire       type_ok  = cmd_type <= 8'(OP_SWAP);
    wire       clr_ok   = cmd_type <= 8'h05;
    wire       xzero    = xreg_r == 32'h0;
    wire       is_divop = cmd_type == 8'(OP_DIV) || cmd_type == 8'(OP_MOD);
    wire       div_go   = take && is_accu_calculate && is_divop && !xzero;
    wire       op_ok    = (is_accu_calculate && type_ok) || is_axis ||
                          (is_glob && bank_ok) || (is_clr && clr_ok);
    wire [7:0] st_now   = op_ok ? `STATUS_OK
                        : ((is_accu_calculate || is_glob || is_clr) ? `STATUS_BAD_VALUE
                        : `STATUS_BAD_CMD);
    wire [63:0] prod    = $signed(accu_r) * $signed(xreg_r);

    // flag clear mask, one bit per flag; type g+1 clears bit g, type 0 clears all
    logic [4:0] clr_mask;
    genvar g;
    generate
        for (g = 0; g < `FLAG_COUNT; g = g + 1) begin : g_clr
            assign clr_mask[g] = take && is_clr &&
                (cmd_type == `FLAG_ALL ||  // see RULE11
                 cmd_type == 8'(g + 1));   // see RULE12 see RULE13 see RULE14
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    // alu
    logic [31:0] accu_nxt;
    logic [31:0] xreg_nxt;
    always_comb begin
        accu_nxt = accu_r;
        xreg_nxt = xreg_r;
        if (state_r == ST_DIV && div_done) begin
            accu_nxt = (op_r == 8'(OP_DIV)) ? div_q : div_r;  // see RULE7
        end else if (take && is_accu_calculate) begin
            case (cmd_type[3:0])
                OP_ADD:  accu_nxt = accu_r + xreg_r;           // see RULE2
                OP_SUB:  accu_nxt = accu_r - xreg_r;
                OP_MUL:  accu_nxt = prod[31:0];
                OP_AND:  accu_nxt = accu_r & xreg_r;           // see RULE3
                OP_OR:   accu_nxt = accu_r | xreg_r;
                OP_XOR:  accu_nxt = accu_r ^ xreg_r;
                OP_NOT:  xreg_nxt = ~xreg_r;                   // see RULE4
                OP_LOAD: xreg_nxt = accu_r;                    // see RULE5
                OP_SWAP: begin                                 // see RULE6
                    accu_nxt = xreg_r;
                    xreg_nxt = accu_r;
                end
                default: accu_nxt = accu_r;                    // see RULE16
            endcase
            if (!type_ok) begin
                accu_nxt = accu_r;
                xreg_nxt = xreg_r;
            end
        end else if (accu_load) begin
            accu_nxt = accu_load_data;
        end
    end
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (div_go) begin
                    state_nxt = ST_DIV;
                end else if (take) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DIV: begin
                if (div_done) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end
    assign div_start = div_go;
    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            accu_r  <= `ACCU_RESET;
            xreg_r  <= `XREG_RESET;
            op_r    <= 8'h0;
        end else begin
            state_r <= state_nxt;
            accu_r  <= accu_nxt;
            xreg_r  <= xreg_nxt;
            if (take) begin
                op_r <= cmd_type;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            flags_r <= 5'h0;
        end else begin
            flags_r <= (flags_r & ~clr_mask) | error_set;  // see RULE10
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            rep_s_r  <= 8'h0;
            ax_wr_r  <= 1'b0;
            gl_wr_r  <= 1'b0;
            wp_num_r <= 8'h0;
            wp_sel_r <= 8'h0;
            wdata_r  <= 32'h0;
        end else begin
            ax_wr_r <= take && is_axis;                    // see RULE8
            gl_wr_r <= take && is_glob && bank_ok;         // see RULE9
            if (take) begin
                rep_s_r  <= st_now;                        // see RULE15
                wp_num_r <= cmd_type;
                wp_sel_r <= cmd_bank;
                wdata_r  <= accu_r;                        // see RULE17
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            rep_v_r <= 1'b0;
        end else begin
            rep_v_r <= state_nxt == ST_DONE;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sdiv32 u_div (
        .mclk      (mclk),
        .srst      (srst),
        .start     (div_start),
        .dividend  (accu_r),
        .divisor   (xreg_r),
        .done      (div_done),
        .quotient  (div_q),
        .remainder (div_r)
    );
    assign cmd_ready        = state_r == ST_IDLE;
    assign reply_valid      = rep_v_r;
    assign reply_status     = rep_s_r;
    assign reply_value      = 32'h0;
    assign accu             = accu_r;
    assign xreg             = xreg_r;
    assign axis_wr          = ax_wr_r;
    assign axis_param_num   = wp_num_r;
    assign axis_motor       = wp_sel_r;
    assign axis_wdata       = wdata_r;
    assign global_wr        = gl_wr_r;
    assign global_param_num = wp_num_r;
    assign global_bank      = wp_sel_r;
    assign global_wdata     = wdata_r;
    assign error_flags      = flags_r;
    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_add_cmd;
        cmd_valid && cmd_ready && is_accu_calculate && cmd_type == 8'h00;
    endsequence
    property p_add;
        @(posedge mclk) disable iff (srst)
        s_add_cmd |=> accu_r == $past(accu_r) + $past(xreg_r);
    endproperty
    a_add: assert property (p_add) else $error("add wrong"); // see RULE2
    property p_and;
        @(posedge mclk) disable iff (srst)
        take && is_accu_calculate && cmd_type == 8'h05 |=>
            accu_r == ($past(accu_r) & $past(xreg_r));
    endproperty
    a_and: assert property (p_and) else $error("and wrong"); // see RULE3
    property p_not;
        @(posedge mclk) disable iff (srst)
        take && is_accu_calculate && cmd_type == 8'h08 |=>
            xreg_r == ~$past(xreg_r) && accu_r == $past(accu_r);
    endproperty
    a_not: assert property (p_not) else $error("not wrong"); // see RULE4
    property p_load;
        @(posedge mclk) disable iff (srst)
        take && is_accu_calculate && cmd_type == 8'h09 |=>
            xreg_r == $past(accu_r) && accu_r == $past(accu_r);
    endproperty
    a_load: assert property (p_load) else $error("load wrong"); // see RULE5
    property p_swap;
        @(posedge mclk) disable iff (srst)
        take && is_accu_calculate && cmd_type == 8'h0a |=>
            xreg_r == $past(accu_r) && accu_r == $past(xreg_r);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong"); // see RULE6
    property p_axis;
        @(posedge mclk) disable iff (srst)
        take && is_axis |=> axis_wr && axis_wdata == $past(accu_r);
    endproperty
    a_axis: assert property (p_axis) else $error("axis write"); // see RULE8
    property p_glob;
        @(posedge mclk) disable iff (srst)
        take && is_glob |=> global_wr == $past(bank_ok);
    endproperty
    a_glob: assert property (p_glob) else $error("global write"); // see RULE9
    property p_clr_all;
        @(posedge mclk) disable iff (srst)
        take && is_clr && cmd_type == 8'h00 |=>
            error_flags == $past(error_set);
    endproperty
    a_clr_all: assert property (p_clr_all) else $error("clear"); // see RULE11
    property p_div0;
        @(posedge mclk) disable iff (srst)
        take && is_accu_calculate && is_divop && xzero |=>
            accu_r == $past(accu_r) ##0 reply_valid;
    endproperty
    a_div0: assert property (p_div0) else $error("div by zero"); // see RULE16
    property p_reply;
        @(posedge mclk) disable iff (srst)
        take && op_ok |-> ##[1:36] reply_valid && reply_status == 8'd100;
    endproperty
    a_reply: assert property (p_reply) else $error("no reply"); // see RULE15
endmodule

// ==== inc/xcalc_defs.svh ====
// constants for the accumulator and x register command executor
`ifndef XCALC_DEFS_SVH
`define XCALC_DEFS_SVH
`define OPC_XREG_ACCU_CALCULATE      8'h21
`define OPC_ACCU_AXIS      8'h22
`define OPC_ACCU_GLOBAL    8'h23
`define OPC_CLEAR_FLAGS    8'h24
`define STATUS_OK          8'h64
`define STATUS_BAD_VALUE   8'h04
`define STATUS_BAD_CMD     8'h02
`define BANK_ALLOWED_0     8'h00
`define BANK_ALLOWED_2     8'h02
`define BANK_ALLOWED_3     8'h03
`define FLAG_ALL           8'h00
`define FLAG_TIMEOUT_BIT   0
`define FLAG_ALARM_BIT     1
`define FLAG_DEVIATION_BIT 2
`define FLAG_POSITION_BIT  3
`define FLAG_SHUTDOWN_BIT  4
`define FLAG_COUNT         5
`define DIV_STEPS          6'd32
`define ACCU_RESET         32'h0000_0000
`define XREG_RESET         32'h0000_0000
`endif

// ==== inc/xcalc_pkg.sv ====
// types for the accumulator and x register command executor
package xcalc_pkg;
    typedef enum logic [3:0] {
        OP_ADD  = 4'h0,
        OP_SUB  = 4'h1,
        OP_MUL  = 4'h2,
        OP_DIV  = 4'h3,
        OP_MOD  = 4'h4,
        OP_AND  = 4'h5,
        OP_OR   = 4'h6,
        OP_XOR  = 4'h7,
        OP_NOT  = 4'h8,
        OP_LOAD = 4'h9,
        OP_SWAP = 4'ha
    } xcalc_op_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIV  = 2'b01,
        ST_DONE = 2'b11
    } exec_state_t;
endpackage

// ==== rtl/sdiv32.sv ====
// signed 32-bit restoring divider, quotient truncates toward zero
`timescale 1ns/1ps
`include "xcalc_defs.svh"
module sdiv32 (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [31:0] divisor,
    output logic             done,
    output logic [31:0]      quotient,
    output logic [31:0]      remainder
);
    logic [31:0] rem_r;
    logic [31:0] quo_r;
    logic [31:0] dsr_r;
    logic [5:0]  cnt_r;
    logic        neg_q_r;
    logic        neg_r_r;
    logic        busy_r;
    logic        done_r;
    wire  [31:0] dd_abs = dividend[31] ? 32'(-dividend) : dividend;
    wire  [31:0] ds_abs = divisor[31] ? 32'(-divisor) : divisor;
    wire  [32:0] shifted = {rem_r, quo_r[31]};
    wire  [32:0] trial = shifted - {1'b0, dsr_r};
    wire         fits = ~trial[32];
    wire  [31:0] rem_nxt = fits ? trial[31:0] : shifted[31:0];
    wire  [31:0] quo_nxt = {quo_r[30:0], fits};
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (srst) begin
            rem_r   <= 32'h0;
            quo_r   <= 32'h0;
            dsr_r   <= 32'h0;
            cnt_r   <= 6'h0;
            neg_q_r <= 1'b0;
            neg_r_r <= 1'b0;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
        end else if (start) begin
            rem_r   <= 32'h0;
            quo_r   <= dd_abs;
            dsr_r   <= ds_abs;
            cnt_r   <= `DIV_STEPS;
            neg_q_r <= dividend[31] ^ divisor[31];
            neg_r_r <= dividend[31];
            busy_r  <= 1'b1;
            done_r  <= 1'b0;
        end else if (busy_r) begin
            rem_r  <= rem_nxt;
            quo_r  <= quo_nxt;
            cnt_r  <= cnt_r - 6'd1;
            busy_r <= (cnt_r != 6'd1);
            done_r <= (cnt_r == 6'd1);
        end else begin
            done_r <= 1'b0;
        end
    end
    assign done      = done_r;
    assign quotient  = neg_q_r ? 32'(-quo_r) : quo_r;
    assign remainder = neg_r_r ? 32'(-rem_r) : rem_r;
endmodule

// ==== bench/cmd_host.sv ====
// host model that issues commands and collects replies
`timescale 1ns/1ps
module cmd_host (
    input  wire logic        mclk,
    input  wire logic        cmd_ready,
    input  wire logic        reply_valid,
    input  wire logic [7:0]  reply_status,
    input  wire logic        axis_wr,
    input  wire logic        global_wr,
    output logic             cmd_valid,
    output logic [7:0]       cmd_opcode,
    output logic [7:0]       cmd_type,
    output logic [7:0]       cmd_bank,
    output logic [31:0]      cmd_value,
    output logic             accu_load,
    output logic [31:0]      accu_load_data
);
    logic [7:0] status;
    logic       got_axis;
    logic       got_glob;
    logic       tmo;
    int         lat;
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        cmd_type = 8'h00;
        cmd_bank = 8'h00;
        cmd_value = 32'h0;
        accu_load = 1'b0;
        accu_load_data = 32'h0;
    end
    ////////////////////////////////////////////////////////////////////
    // accumulator load ahead of a transfer
    task automatic load(input logic [31:0] v);
        accu_load = 1'b1;
        accu_load_data = v;
        @(negedge mclk);
        accu_load = 1'b0;
        accu_load_data = ~v;
    endtask
    ////////////////////////////////////////////////////////////////////
    // one command: wait ready, hold for one rising edge, wait bounded for reply
    task automatic send(input logic [7:0] op, input logic [7:0] ty,
                        input logic [7:0] bk, input logic [31:0] val);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_opcode = op;
        cmd_type = ty;
        cmd_bank = bk;
        cmd_value = val;
        @(posedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_opcode = ~op;
        cmd_type = ~ty;
        cmd_bank = ~bk;
        cmd_value = ~val;
        lat = 1;
        while (reply_valid !== 1'b1 && lat < 40) begin
            @(negedge mclk);
            lat++;
        end
        tmo = (reply_valid !== 1'b1) || (n == 40);
        status = reply_status;
        got_axis = axis_wr;
        got_glob = global_wr;
        @(negedge mclk);
    endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the accumulator and x register executor
`timescale 1ns/1ps
`include "xcalc_defs.svh"
module tb_top;
    typedef struct packed {
        logic [7:0]  ty;
        logic [31:0] a;
        logic [31:0] x;
        logic [31:0] ea;
        logic [31:0] ex;
        int          lat;
    } row_t;
    logic        mclk;
    logic        srst;
    logic [4:0]  error_set;
    logic [4:0]  fexp;
    logic [7:0]  sexp;
    wire         cmd_valid, cmd_ready, reply_valid, accu_load;
    wire         axis_wr, global_wr;
    wire [7:0]   cmd_opcode, cmd_type, cmd_bank, reply_status;
    wire [7:0]   axis_param_num, axis_motor, global_param_num, global_bank;
    wire [31:0]  cmd_value, accu_load_data, accu, xreg;
    wire [31:0]  axis_wdata, global_wdata;
    wire [4:0]   error_flags;
    int          error_cnt = 0;
    int          total_checks = 0;
    row_t        rows [13] = '{
        '{8'h00, 32'h5, 32'h3, 32'h8, 32'h3, 1},
        '{8'h01, 32'h5, 32'h7, 32'hffff_fffe, 32'h7, 1},
        '{8'h02, 32'hffff_fffd, 32'h7, 32'hffff_ffeb, 32'h7, 1},
        '{8'h03, 32'hffff_fff9, 32'h2, 32'hffff_fffd, 32'h2, 34},
        '{8'h04, 32'hffff_fff9, 32'h2, 32'hffff_ffff, 32'h2, 34},
        '{8'h05, 32'hf0f0ff00, 32'h0ff00ff0, 32'h00f00f00, 32'h0ff00ff0, 1},
        '{8'h06, 32'hf0f0ff00, 32'h0ff00ff0, 32'hfff0fff0, 32'h0ff00ff0, 1},
        '{8'h07, 32'hf0f0ff00, 32'h0ff00ff0, 32'hff00f0f0, 32'h0ff00ff0, 1},
        '{8'h08, 32'h1234, 32'hff, 32'h1234, 32'hffff_ff00, 1},
        '{8'h09, 32'habcd, 32'h5, 32'habcd, 32'habcd, 1},
        '{8'h0a, 32'h11, 32'h22, 32'h22, 32'h11, 1},
        '{8'h03, 32'h99, 32'h0, 32'h99, 32'h0, 1},
        '{8'h04, 32'h99, 32'h0, 32'h99, 32'h0, 1}};

    accu_xreg_exec DUT (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_type(cmd_type),
        .cmd_bank(cmd_bank), .cmd_value(cmd_value),
        .reply_valid(reply_valid), .reply_status(reply_status),
        .reply_value(), .accu_load(accu_load),
        .accu_load_data(accu_load_data), .accu(accu), .xreg(xreg),
        .axis_wr(axis_wr), .axis_param_num(axis_param_num),
        .axis_motor(axis_motor), .axis_wdata(axis_wdata),
        .global_wr(global_wr), .global_param_num(global_param_num),
        .global_bank(global_bank), .global_wdata(global_wdata),
        .error_set(error_set), .error_flags(error_flags));
    cmd_host host (.mclk(mclk), .cmd_ready(cmd_ready),
        .reply_valid(reply_valid), .reply_status(reply_status),
        .axis_wr(axis_wr), .global_wr(global_wr), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_type(cmd_type), .cmd_bank(cmd_bank),
        .cmd_value(cmd_value), .accu_load(accu_load),
        .accu_load_data(accu_load_data));
    ////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] ty,
                       input logic [7:0] bk);
        host.send(op, ty, bk, 32'hdead_beef);
        if (host.tmo) begin
            error_cnt++;
            summarize();
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        error_set = 5'h00;
        repeat (4) @(negedge mclk);
        check({accu[31:1], cmd_ready}, 32'h1);
        check({xreg[31:5], error_flags}, 32'h0);
        srst = 1'b0;
        @(negedge mclk);
        foreach (rows[i]) begin
            host.load(rows[i].x);
            cmd(`OPC_XREG_ACCU_CALCULATE, 8'h09, 8'h5b);
            host.load(rows[i].a);
            cmd(`OPC_XREG_ACCU_CALCULATE, rows[i].ty, 8'h5b);
            check(accu, rows[i].ea);
            check(xreg, rows[i].ex);
            check({24'h0, host.status}, {24'h0, `STATUS_OK});
            if (rows[i].lat > 0) begin
                check(32'(host.lat), 32'(rows[i].lat));
            end
        end
        host.load(32'h1234_5678);
        cmd(`OPC_ACCU_AXIS, 8'h04, 8'h00);
        check({30'h0, host.got_axis, host.got_glob}, 32'h2);
        check({axis_param_num, axis_motor}, 32'h0400);
        check(axis_wdata, 32'h1234_5678);
        check({24'h0, host.status}, {24'h0, `STATUS_OK});
        for (int b = 0; b < 4; b++) begin
            host.load(32'hc0de_0000 + b);
            cmd(`OPC_ACCU_GLOBAL, 8'h2a, 8'(b));
            check({31'h0, host.got_glob}, {31'h0, b != 1});
            sexp = b == 1 ? `STATUS_BAD_VALUE : `STATUS_OK;
            check({24'h0, host.status}, {24'h0, sexp});
            if (b != 1) begin
                check({global_param_num, global_bank}, 32'h2a00 + b);
                check(global_wdata, 32'hc0de_0000 + b);
            end
        end
        for (int t = 0; t < 7; t++) begin
            error_set = 5'h1f;
            @(negedge mclk);
            error_set = 5'h00;
            cmd(`OPC_CLEAR_FLAGS, 8'(t), 8'h77);
            fexp = t == 0 ? 5'h00 : t == 6 ? 5'h1f : ~(5'h01 << (t - 1));
            check(error_flags, fexp);
            sexp = t == 6 ? `STATUS_BAD_VALUE : `STATUS_OK;
            check({24'h0, host.status}, {24'h0, sexp});
        end
        // a new error in the clearing cycle wins over the clear
        error_set = 5'h04;
        fork
            cmd(`OPC_CLEAR_FLAGS, 8'h00, 8'h00);
            begin
                @(negedge mclk);
                error_set = 5'h00;
            end
        join
        check({27'h0, error_flags}, 32'h4);
        cmd(8'h25, 8'h00, 8'h00);
        check({24'h0, host.status}, {24'h0, `STATUS_BAD_CMD});
        // reset in mid run, then a request at the first edge after it
        error_set = 5'h1f;
        host.load(32'h0bad_cafe);
        cmd(`OPC_XREG_ACCU_CALCULATE, 8'h09, 8'h00);
        srst = 1'b1;
        repeat (2) @(negedge mclk);
        check({accu[31:1], cmd_ready}, 32'h1);
        check({xreg[31:5], error_flags}, 32'h0);
        check({24'h0, reply_status}, 32'h0);
        check({29'h0, reply_valid, axis_wr, global_wr}, 32'h0);
        error_set = 5'h00;
        srst = 1'b0;
        host.load(32'h0000_0007);
        cmd(`OPC_XREG_ACCU_CALCULATE, 8'h00, 8'h00);
        check(accu, 32'h7);
        // unknown calculation type leaves both registers alone
        cmd(`OPC_XREG_ACCU_CALCULATE, 8'h0b, 8'h00);
        check(accu, 32'h7);
        check(xreg, 32'h0);
        check({24'h0, host.status}, {24'h0, `STATUS_BAD_VALUE});
        summarize();
    end
endmodule
